// ===== verilog/sar_adc_sequencer.sv
// converter sequencer top: Avalon-MM register slave, start control and interrupt
`timescale 1ns/100ps
`include "sar_adc_cfg.svh"
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave, byte addressed
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // analog front end
  input wire logic comparator_high,
  output logic [1:0] analog_channel,
  output logic analog_channel_valid,
  output logic reference_connect,
  output logic sample_hold_enable,
  output logic [9:0] dac_code,
  // timer capture request, one-cycle pulse
  input wire logic capture_request,
  // status and interrupts
  output logic conv_busy,
  output logic conv_done_pulse,
  output logic irq
);
  import sar_adc_pkg::*;

  top_state_t s;
  top_state_t next_s;
  conv_if bus();
  logic req;
  logic acc_wr;
  logic [9:0] widx;
  logic [7:0] wbyte;
  logic start_cmd;
  logic abort_cmd;
  logic ch_ok;

  // true when a byte address hits the register of the given index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx);
  endfunction : hit

  // a channel code is legal only with the top bit set
  function automatic logic code_legal(input logic [2:0] code);
    code_legal = code[2];
  endfunction : code_legal

  conv_clock_div u_div (
    .core_clk(core_clk),
    .rst(rst),
    .bus(bus)
  );

  sar_step_engine u_engine (
    .core_clk(core_clk),
    .rst(rst),
    .bus(bus)
  );

  // links to the divider and engine
  assign bus.clock_sel = {s.conv_clock_select_hi, s.conv_clock_select_lo}; // R12
  assign bus.res10 = s.res10;
  assign bus.sample_hold = s.sample_hold_enable;
  assign bus.comparator_high = comparator_high;
  assign bus.start = start_cmd;
  assign bus.abort = abort_cmd;

  // bus handshake: one wait cycle, then the access completes
  assign req = read | write;
  assign waitrequest = req & ~s.ack;
  assign readdata = s.rdata;
  assign acc_wr = write & s.ack & byteenable[0];
  assign widx = address[11:2];
  assign wbyte = writedata[7:0];

  // outputs to the analog side
  assign ch_ok = s.input_group_enable & code_legal(s.active_ch); // R1 R2
  assign analog_channel = s.active_ch[1:0]; // R1
  assign analog_channel_valid = ch_ok; // R2
  assign reference_connect = s.reference_connect; // R14
  assign sample_hold_enable = s.sample_hold_enable;
  assign dac_code = bus.dac_code;
  assign conv_busy = (s.fsm == ST_CONV);
  assign conv_done_pulse = s.done_pulse; // R18
  assign irq = s.irq_status & s.irq_mask;

  always_comb
  begin
    next_s = s;
    next_s.done_pulse = 1'b0;
    start_cmd = 1'b0;
    abort_cmd = 1'b0;
    next_s.ack = req & ~s.ack;

    // read data captured in the wait cycle so it stands at the completing edge;
    // writes leave it alone so software sees the last read until the next one
    if (read && !s.ack)
    begin
      next_s.rdata = '0;
      if (hit(address, `REG_CONTROL_0))
      begin
        next_s.rdata[`C0_CH_LSB +: 3] = s.ch;
        next_s.rdata[`C0_REPEAT] = s.repeat_mode_select;
        next_s.rdata[`C0_GROUP] = s.input_group_enable;
        next_s.rdata[`C0_AUTO] = s.auto_start_select;
        next_s.rdata[`C0_START] = s.conv_start_flag;
        next_s.rdata[`C0_CLK_LO] = s.conv_clock_select_lo;
      end
      else if (hit(address, `REG_CONTROL_1))
      begin
        next_s.rdata[`C1_RES10] = s.res10;
        next_s.rdata[`C1_CLK_HI] = s.conv_clock_select_hi;
        next_s.rdata[`C1_REF] = s.reference_connect;
      end
      else if (hit(address, `REG_RESULT))
        next_s.rdata[9:0] = s.result; // R15
      else if (hit(address, `REG_CONTROL_2))
        next_s.rdata[`C2_SAMPLE_HOLD] = s.sample_hold_enable;
      else if (hit(address, `REG_IRQ_STATUS))
        next_s.rdata[`IRQ_DONE] = s.irq_status;
      else if (hit(address, `REG_IRQ_MASK))
        next_s.rdata[`IRQ_DONE] = s.irq_mask;
    end

    // register writes; the result register is read-only, unmapped writes vanish
    if (acc_wr)
    begin
      if (widx == `REG_CONTROL_0)
      begin
        next_s.ch = wbyte[`C0_CH_LSB +: 3];
        // channel code reaches the multiplexer only while the group is already on
        if (s.input_group_enable)
          next_s.active_ch = wbyte[`C0_CH_LSB +: 3]; // R3
        next_s.repeat_mode_select = wbyte[`C0_REPEAT];
        next_s.input_group_enable = wbyte[`C0_GROUP]; // R2
        next_s.auto_start_select = wbyte[`C0_AUTO];
        next_s.conv_start_flag = wbyte[`C0_START];
        next_s.conv_clock_select_lo = wbyte[`C0_CLK_LO];
        if (!wbyte[`C0_START] && s.fsm == ST_CONV)
          abort_cmd = 1'b1; // R7 R19
      end
      if (widx == `REG_CONTROL_1)
      begin
        next_s.res10 = wbyte[`C1_RES10]; // R10
        next_s.conv_clock_select_hi = wbyte[`C1_CLK_HI];
        next_s.reference_connect = wbyte[`C1_REF]; // R14
      end
      if (widx == `REG_CONTROL_2)
        next_s.sample_hold_enable = wbyte[`C2_SAMPLE_HOLD];
      if (widx == `REG_IRQ_STATUS && wbyte[`IRQ_DONE])
        next_s.irq_status = 1'b0;
      if (widx == `REG_IRQ_MASK)
        next_s.irq_mask = wbyte[`IRQ_DONE];
    end

    // start, stop and completion sequencing
    unique case (s.fsm)
      ST_IDLE:
      begin
        // an illegal channel or a closed group simply never starts
        if (s.conv_start_flag && ch_ok && !abort_cmd)
        begin
          if (!s.auto_start_select)
          begin
            start_cmd = 1'b1; // R8
            next_s.fsm = ST_CONV;
          end
          else
            next_s.fsm = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        if (!s.conv_start_flag || !ch_ok)
          next_s.fsm = ST_IDLE; // R9
        else if (capture_request)
        begin
          start_cmd = 1'b1; // R9
          next_s.fsm = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (abort_cmd || !s.conv_start_flag)
        begin
          abort_cmd = 1'b1; // R19
          next_s.fsm = ST_IDLE; // R7
        end
        else if (bus.done)
        begin
          next_s.result = bus.result; // R15
          if (!s.repeat_mode_select)
          begin
            // a start written in this very cycle keeps the flag set
            if (!(acc_wr && widx == `REG_CONTROL_0 && wbyte[`C0_START]))
              next_s.conv_start_flag = 1'b0; // R5 R18
            next_s.done_pulse = 1'b1; // R4 R18
            next_s.fsm = ST_IDLE; // R4
          end
          else
            start_cmd = 1'b1; // R6
        end
      end
    endcase

    // sticky done flag: a new completion beats a clear in the same cycle
    if (next_s.done_pulse)
      next_s.irq_status = 1'b1; // R4
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.fsm <= ST_IDLE;
    end
    else
      s <= next_s;
  end
endmodule : sar_adc_sequencer

// ===== verilog/sar_adc_cfg.svh
// register map, field positions, reset values and timing counts of the converter sequencer
//
// How it works
// R1: channel code 100..111 selects analog inputs 0..3; other codes never start conversion.
// R2: input group enable gates the channel selection onto the analog multiplexer.
// R3: software rewrites the channel bits after enabling the input group.
// R4: one-shot mode converts once per start and raises a completion interrupt.
// R5: one-shot completion clears the start flag by hardware.
// R6: repeat mode converts back to back with no completion interrupt.
// R7: writing zero to the start flag stops activity in both modes.
// R8: with auto-start off, writing one to the start flag starts at once.
// R9: with auto-start on, a capture request while the flag is one starts.
// R10: resolution bit picks 8 or 10 approximation steps.
// R11: software uses only 8-bit resolution in repeat mode.
// R12: clock select picks quarter, half or undivided clock; code 11 forbidden.
// R13: without sample-and-hold, conversion takes 49 or 59 converter clocks.
// R14: reference connect bit at zero cuts the reference from the ladder.
// R15: every finished conversion lands in the result register.
// R16: software sets shared analog pins as port inputs before converting.
// R17: with sample-and-hold, conversion takes 28 or 33 converter clocks.
// R18: completion pulse, result write and flag clear happen in one cycle.
// R19: clearing the start flag mid-conversion aborts and keeps the old result.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// register indices; byte address is four times the index
`define REG_CONTROL_0 10'h0d6
`define REG_CONTROL_1 10'h0d7
`define REG_RESULT 10'h0d8
`define REG_CONTROL_2 10'h0d9
`define REG_IRQ_STATUS 10'h0da
`define REG_IRQ_MASK 10'h0db

// converter_control_0 fields
`define C0_CH_LSB 0
`define C0_REPEAT 3
`define C0_GROUP 4
`define C0_AUTO 5
`define C0_START 6
`define C0_CLK_LO 7

// converter_control_1 fields
`define C1_RES10 3
`define C1_CLK_HI 4
`define C1_REF 5

// converter_control_2 and interrupt fields
`define C2_SAMPLE_HOLD 0
`define IRQ_DONE 0

// reset values
`define RESET_CONTROL_0 8'h00
`define RESET_CONTROL_1 8'h00
`define RESET_CONTROL_2 8'h00

// conversion lengths in converter clocks
`define CYC_8_PLAIN 6'd49
`define CYC_10_PLAIN 6'd59
`define CYC_8_HOLD 6'd28
`define CYC_10_HOLD 6'd33
`define CYC_SAMPLE 6'd4

`endif

// ===== verilog/sar_adc_pkg.sv
// types shared by the converter sequencer modules
package sar_adc_pkg;
  `include "sar_adc_cfg.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [2:0] ch;
    logic repeat_mode_select;
    logic input_group_enable;
    logic auto_start_select;
    logic conv_start_flag;
    logic conv_clock_select_lo;
    logic res10;
    logic conv_clock_select_hi;
    logic reference_connect;
    logic sample_hold_enable;
    logic [2:0] active_ch;
    logic [9:0] result;
    logic irq_status;
    logic irq_mask;
    logic ack;
    logic [31:0] rdata;
    seq_state_t fsm;
    logic done_pulse;
  } top_state_t;

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [3:0] bit_idx;
    logic bits_done;
    logic [9:0] sar;
    logic [9:0] result;
    logic done;
  } engine_state_t;

  typedef struct packed {
    logic [1:0] cnt;
  } div_state_t;

  // total converter clocks for one conversion
  function automatic logic [5:0] conv_cycles(input logic res10, input logic hold);
    if (hold)
      conv_cycles = res10 ? `CYC_10_HOLD : `CYC_8_HOLD;
    else
      conv_cycles = res10 ? `CYC_10_PLAIN : `CYC_8_PLAIN;
  endfunction : conv_cycles
endpackage : sar_adc_pkg

// ===== verilog/conv_if.sv
// signals between the sequencer, the clock divider and the approximation engine
`timescale 1ns/100ps
interface conv_if;
  logic [1:0] clock_sel;
  logic tick;
  logic start;
  logic abort;
  logic res10;
  logic sample_hold;
  logic comparator_high;
  logic done;
  logic busy;
  logic [9:0] result;
  logic [9:0] dac_code;

  modport ctrl (output clock_sel, start, abort, res10, sample_hold, comparator_high,
    input tick, done, busy, result, dac_code);
  modport div (input clock_sel, output tick);
  modport engine (input tick, start, abort, res10, sample_hold, comparator_high,
    output done, busy, result, dac_code);
endinterface : conv_if

// ===== verilog/conv_clock_div.sv
// converter clock enable divider
`timescale 1ns/100ps
module conv_clock_div
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link to sequencer
  conv_if.div bus
);
  import sar_adc_pkg::*;

  div_state_t s;
  div_state_t next_s;

  // free running counter; the forbidden code falls back to quarter rate
  always_comb
  begin
    next_s = s;
    next_s.cnt = s.cnt + 2'd1;
    unique case (bus.clock_sel)
      2'b10: bus.tick = 1'b1; // R12
      2'b01: bus.tick = s.cnt[0]; // R12
      default: bus.tick = (s.cnt == 2'd3); // R12
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : conv_clock_div

// ===== verilog/sar_step_engine.sv
// successive approximation step engine, counted in converter clocks
`timescale 1ns/100ps
`include "sar_adc_cfg.svh"
module sar_step_engine
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link to sequencer
  conv_if.engine bus
);
  import sar_adc_pkg::*;

  engine_state_t s;
  engine_state_t next_s;
  logic [5:0] total;

  assign bus.done = s.done;
  assign bus.busy = s.busy;
  assign bus.result = s.result;
  assign bus.dac_code = s.sar;

  // one bit decided per converter clock after sampling, then idle till the full count
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    total = conv_cycles(bus.res10, bus.sample_hold); // R13 R17
    if (bus.start)
    begin
      next_s.busy = 1'b1;
      next_s.cnt = '0;
      next_s.bits_done = 1'b0;
      next_s.bit_idx = bus.res10 ? 4'd9 : 4'd7; // R10
      next_s.sar = bus.res10 ? 10'h200 : 10'h080; // R10
    end
    else if (bus.abort)
      next_s.busy = 1'b0; // R19
    else if (s.busy && bus.tick)
    begin
      next_s.cnt = s.cnt + 6'd1;
      if (s.cnt >= `CYC_SAMPLE && !s.bits_done)
      begin
        if (!bus.comparator_high)
          next_s.sar[s.bit_idx] = 1'b0;
        if (s.bit_idx == 4'd0)
          next_s.bits_done = 1'b1;
        else
        begin
          next_s.bit_idx = s.bit_idx - 4'd1;
          next_s.sar[s.bit_idx - 4'd1] = 1'b1;
        end
      end
      if (s.cnt == total - 6'd1)
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1; // R13 R17
        next_s.result = next_s.sar;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : sar_step_engine

// ===== test/sar_adc_props.sv
// port assertions for the converter sequencer
`timescale 1ns/100ps
module sar_adc_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // converter
  input wire logic analog_channel_valid,
  input wire logic reference_connect,
  input wire logic conv_busy,
  input wire logic conv_done_pulse,
  input wire logic irq
);
  logic [11:0] busy_len;
  logic busy_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // length of the last busy run, held after busy drops so the done pulse can be judged
  always_ff @(posedge core_clk)
  begin
    busy_q <= rst ? 1'b0 : conv_busy;
    if (rst)
      busy_len <= 12'h000;
    else if (conv_busy && !busy_q)
      busy_len <= 12'h001;
    else if (conv_busy && busy_len != 12'hfff)
      busy_len <= busy_len + 12'h001;
  end
  property p_wait_first;
    $rose(read) || $rose(write) |-> waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
  property p_wait_second;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_second: assert property (p_wait_second) else $error("wait too long");
  property p_rd_hold;
    !read |=> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_pulse_one;
    conv_done_pulse |=> !conv_done_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("done pulse too long");
  property p_pulse_after_busy;
    conv_done_pulse |-> $past(conv_busy) || $past(conv_busy, 2);
  endproperty
  a_pulse_after_busy: assert property (p_pulse_after_busy) else $error("stray done");
  property p_busy_valid;
    $rose(conv_busy) |-> analog_channel_valid;
  endproperty
  a_busy_valid: assert property (p_busy_valid) else $error("start on bad channel");
  property p_conv_len;
    conv_done_pulse |-> busy_len >= 12'd26 && busy_len <= 12'd250;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad conversion length");
  property p_irq_cause;
    $rose(irq) |-> conv_done_pulse || $past(write);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  // reset itself is the antecedent, so this one cannot be disabled by it
  property p_reset_out;
    disable iff (1'b0) rst |=> !conv_busy && !irq && !reference_connect && readdata == 32'h0;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared");
endmodule : sar_adc_props

bind sar_adc_sequencer sar_adc_props sar_adc_props_i (.core_clk, .rst, .read, .write,
  .readdata, .waitrequest, .analog_channel_valid, .reference_connect, .conv_busy,
  .conv_done_pulse, .irq);

// ===== test/analog_front_model.sv
// far-side analog model: four fixed input levels and a comparator
`timescale 1ns/100ps
module analog_front_model #(
  parameter logic [39:0] LEVELS = 40'h0
) (
  // from the sequencer
  input wire logic [1:0] analog_channel,
  input wire logic analog_channel_valid,
  input wire logic reference_connect,
  input wire logic [9:0] dac_code,
  // to the sequencer
  output logic comparator_high
);
  logic [9:0] level;
  // a cut reference or a deselected input leaves the comparator low
  always_comb
  begin
    // shared pins act as plain inputs here; nothing in the model drives them
    level = LEVELS[analog_channel * 10 +: 10];
    comparator_high = analog_channel_valid && reference_connect && level >= dac_code;
  end
endmodule : analog_front_model

// ===== test/tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module tb_top;
  import sar_adc_pkg::*;
  `include "sar_adc_cfg.svh"
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic capture_request = 1'b0;
  logic [31:0] readdata;
  logic waitrequest, comparator_high, analog_channel_valid, reference_connect;
  logic sample_hold_enable, conv_busy, conv_done_pulse, irq;
  logic [1:0] analog_channel;
  logic [9:0] dac_code;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [9:0] lv [4] = '{10'h05a, 10'h0a5, 10'h03c, 10'h0c3};

  sar_adc_sequencer sar_adc_sequencer_i (.core_clk, .rst, .address, .read, .write,
    .byteenable(4'h1), .writedata, .readdata, .waitrequest, .comparator_high,
    .analog_channel, .analog_channel_valid, .reference_connect, .sample_hold_enable,
    .dac_code, .capture_request, .conv_busy, .conv_done_pulse, .irq);
  analog_front_model #(.LEVELS({10'h0c3, 10'h03c, 10'h0a5, 10'h05a})) analog_front_model_i (
    .analog_channel, .analog_channel_valid, .reference_connect, .dac_code, .comparator_high);

  always #12.5 core_clk = ~core_clk;
  // hang guard, far above the roughly 1300 cycles the scenarios need
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [9:0] r, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge core_clk);
    address <= {r, 2'b00};
    writedata <= {24'h0, d};
    write <= w;
    read <= !w;
    do
      @(posedge core_clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : acc
  task automatic wr(input logic [9:0] r, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, r, d, q);
  endtask : wr
  task automatic rck(input string n, input logic [9:0] r, input logic [31:0] m, e);
    logic [31:0] q;
    acc(1'b0, r, 8'h00, q);
    chk(n, q & m, e);
  endtask : rck
  // cycles from the start write to the done pulse, bounded
  task automatic wait_done(output int n);
    n = 0;
    while (conv_done_pulse !== 1'b1 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_done
  task automatic cap;
    capture_request <= 1'b1;
    @(posedge core_clk);
    capture_request <= 1'b0;
  endtask : cap

  task automatic t_regs;
    rck("ctl0", `REG_CONTROL_0, 32'hff, `RESET_CONTROL_0);
    rck("ctl1", `REG_CONTROL_1, 32'hff, `RESET_CONTROL_1);
    rck("ctl2", `REG_CONTROL_2, 32'hff, `RESET_CONTROL_2);
    rck("unmapped", 10'h0e0, 32'hffffffff, 32'h0);
    wr(`REG_RESULT, 8'hff);
    rck("result", `REG_RESULT, 32'hffffffff, 32'h0);
    wr(`REG_CONTROL_1, 8'h20);
    tick(2);
    chk("ref", reference_connect, 1'b1);
    wr(`REG_CONTROL_0, 8'h14);
    tick(2);
    chk("valid", analog_channel_valid, 1'b0);
    wr(`REG_CONTROL_0, 8'h14);
    tick(2);
    chk("valid", analog_channel_valid, 1'b1);
  endtask : t_regs
  // every resolution, hold setting and clock code, one channel each
  task automatic t_oneshot;
    int n, e, dv;
    logic hi, lo;
    wr(`REG_IRQ_MASK, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      hi = i[1];
      lo = i[0];
      dv = hi ? (lo ? 4 : 1) : (lo ? 2 : 4);
      e = dv * (i[1] ? (i[0] ? 33 : 28) : (i[0] ? 59 : 49));
      wr(`REG_CONTROL_1, {3'b001, hi, i[0], 3'b000});
      wr(`REG_CONTROL_2, {7'h0, i[1]});
      wr(`REG_CONTROL_0, {lo, 5'b10101, i[1:0]});
      wait_done(n);
      chk("len", n >= e - dv && n <= e + dv + 4, 1'b1);
      chk("chan", analog_channel, i[1:0]);
      chk("dac", dac_code, lv[i]);
      chk("hold", sample_hold_enable, i[1]);
      rck("result", `REG_RESULT, 32'h3ff, {22'h0, lv[i]});
      rck("start", `REG_CONTROL_0, 32'h40, 32'h0);
      chk("irq", irq, 1'b1);
      wr(`REG_IRQ_STATUS, 8'h01);
      tick(1);
      chk("irq", irq, 1'b0);
    end
  endtask : t_oneshot
  task automatic t_abort;
    logic p;
    p = 1'b0;
    wr(`REG_CONTROL_0, 8'h53);
    tick(4);
    chk("valid", analog_channel_valid, 1'b0);
    chk("busy", conv_busy, 1'b0);
    wr(`REG_CONTROL_0, 8'h54);
    tick(10);
    wr(`REG_CONTROL_0, 8'h14);
    tick(2);
    chk("busy", conv_busy, 1'b0);
    repeat (60) @(posedge core_clk) p |= conv_done_pulse;
    chk("pulse", p, 1'b0);
    rck("result", `REG_RESULT, 32'h3ff, {22'h0, lv[3]});
    chk("irq", irq, 1'b0);
  endtask : t_abort
  task automatic t_repeat;
    logic p;
    p = 1'b0;
    wr(`REG_CONTROL_1, 8'h20);
    wr(`REG_CONTROL_2, 8'h00);
    wr(`REG_CONTROL_0, 8'hdd);
    repeat (400) @(posedge core_clk) p |= conv_done_pulse;
    chk("pulse", p | irq, 1'b0);
    chk("busy", conv_busy, 1'b1);
    rck("result", `REG_RESULT, 32'h3ff, {22'h0, lv[1]});
    rck("start", `REG_CONTROL_0, 32'h40, 32'h40);
    wr(`REG_CONTROL_0, 8'h9d);
    tick(3);
    chk("busy", conv_busy, 1'b0);
  endtask : t_repeat
  task automatic t_auto;
    int n;
    wr(`REG_IRQ_MASK, 8'h00);
    wr(`REG_CONTROL_0, 8'h36);
    cap;
    tick(4);
    chk("busy", conv_busy, 1'b0);
    wr(`REG_CONTROL_0, 8'h76);
    tick(8);
    chk("busy", conv_busy, 1'b0);
    cap;
    tick(2);
    chk("busy", conv_busy, 1'b1);
    wait_done(n);
    rck("result", `REG_RESULT, 32'h3ff, {22'h0, lv[2]});
    chk("irq", irq, 1'b0);
    rck("status", `REG_IRQ_STATUS, 32'h1, 32'h1);
    wr(`REG_IRQ_STATUS, 8'h01);
    rck("status", `REG_IRQ_STATUS, 32'h1, 32'h0);
  endtask : t_auto

  // reset for ten cycles, then the scenarios in turn
  initial
  begin
    tick(10);
    rst <= 1'b0;
    tick(1);
    t_regs;
    t_oneshot;
    t_abort;
    t_repeat;
    t_auto;
    complete_run;
  end
endmodule : tb_top
